// ===== dftr_pkg.sv
// Purpose: Shared constants and types of the drive fault, trip and reset manager.
// Assumes: A 10 MHz system clock.
// Notes: Fault and display codes are byte-wide.

package dftr_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_KHZ = 10_000;
  localparam int RECOVER_MS = 1000;
  localparam int RECOVER_CYC = RECOVER_MS * CLK_KHZ;
  localparam int RES_MIN_MS = 100;
  localparam int RES_MIN_CYC = RES_MIN_MS * CLK_KHZ;

  // ==========================================================================
  // Drive phase
  // ==========================================================================
  localparam logic [1:0] PH_ACCEL = 2'h0;
  localparam logic [1:0] PH_CONST = 2'h1;
  localparam logic [1:0] PH_DECEL = 2'h2;
  localparam logic [1:0] PH_STOP = 2'h3;

  // ==========================================================================
  // Fault and display codes
  // ==========================================================================
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_OC_ACCEL = 8'h01;
  localparam logic [7:0] FC_OC_CONST = 8'h02;
  localparam logic [7:0] FC_OC_DECEL = 8'h03;
  localparam logic [7:0] FC_OV_ACCEL = 8'h04;
  localparam logic [7:0] FC_OV_CONST = 8'h05;
  localparam logic [7:0] FC_OV_DECEL = 8'h06;
  localparam logic [7:0] FC_RETRY_EXCESS = 8'h07;
  localparam logic [7:0] FC_GENERIC = 8'h0e;
  localparam logic [7:0] FC_MARK_LO = 8'h20;
  localparam logic [7:0] FC_MARK_HI = 8'h2f;
  localparam logic [7:0] DISP_RESET = 8'h80;
  localparam logic [7:0] DISP_STALL_OC = 8'h81;
  localparam logic [7:0] DISP_STALL_OV = 8'h82;
  localparam logic [7:0] DISP_ALARM = 8'h83;
  localparam logic [7:0] RETRY_LIMIT_DEF = 8'h05;

  // ==========================================================================
  // States
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_RECOVER = 2'b00,
    ST_RUN = 2'b01,
    ST_TRIP = 2'b10,
    ST_HOLD = 2'b11
  } dftr_state_t;

endpackage

// ===== dftr_manager.sv
// Purpose: Sorts abnormal conditions, trips the drive output on faults and manages reset and recovery.
// Assumes: Panel stop key, reset request and power-good arrive asynchronously from pins.
// Notes: Fault detectors, warnings and alarms arrive from logic on the same clock.
//
// What this block does
// [RULE1] Any fault stops the power output and shows that fault on the display.
// [RULE2] After a trip the output stays stopped until an accepted reset.
// [RULE3] Error messages from panel or parameter unit are only displayed, never trip.
// [RULE4] Warnings are displayed and never trip the output.
// [RULE5] Alarms never trip; when enabled an alarm output is driven.
// [RULE6] Faults trip the output and raise the fault output together.
// [RULE7] Every reset clears thermal integration and the automatic restart count.
// [RULE8] After reset release the block waits about one second before running.
// [RULE9] The stop key resets only while a fault trip is active.
// [RULE10] Power loss then restore resets the block and clears any trip.
// [RULE11] A reset request held longer than 0.1 s is a valid reset.
// [RULE12] While the reset request stays active, stay in reset with flashing reset indication.
// [RULE13] Overcurrent trips get three codes by accel, constant or decel/stop phase.
// [RULE14] Overvoltage trips get three codes by the same three phases.
// [RULE15] Active stall prevention shows separate non-tripping overcurrent and overvoltage warnings.
// [RULE16] For the older parameter unit marked fault codes display as generic 14.
// [RULE17] Error messages leave the output running and unaffected.
// [RULE18] The tripping fault code is latched and held until the next reset.

`timescale 1ns/1ns

module dftr_manager #(
  parameter int RECOVER_CYC = dftr_pkg::RECOVER_CYC,
  parameter int RES_MIN_CYC = dftr_pkg::RES_MIN_CYC,
  parameter logic [7:0] RETRY_LIMIT = dftr_pkg::RETRY_LIMIT_DEF
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic stop_key_i,
  input wire logic reset_request_input_i,
  input wire logic power_ok_i,
  input wire logic [1:0] drive_phase_i,
  input wire logic overcurrent_det_i,
  input wire logic overvoltage_det_i,
  input wire logic ext_fault_i,
  input wire logic [7:0] ext_fault_code_i,
  input wire logic retry_attempt_i,
  input wire logic stall_overcurrent_warning_i,
  input wire logic stall_overvoltage_warning_i,
  input wire logic alarm_det_i,
  input wire logic alarm_out_en_i,
  input wire logic err_msg_i,
  input wire logic [7:0] err_msg_code_i,
  input wire logic legacy_unit_i,
  output logic trip_o,
  output logic fault_o,
  output logic alarm_o,
  output logic ready_o,
  output logic [7:0] fault_code_o,
  output logic [7:0] disp_code_o,
  output logic disp_flash_o,
  output logic thermal_clear_o,
  output logic [7:0] retry_count_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    dftr_pkg::dftr_state_t state;
    logic [31:0] res_cnt;
    logic [31:0] rec_cnt;
    logic [1:0] stop_s;
    logic stop_prev;
    logic [1:0] res_s;
    logic [1:0] pwr_s;
    logic [7:0] code;
    logic [7:0] retry_cnt;
    logic trip;
    logic fault;
    logic alarm;
    logic ready;
    logic [7:0] disp;
    logic flash;
    logic thermal_clr;
  } dftr_regs_t;

  dftr_regs_t st_reg;
  dftr_regs_t st_next;

  localparam dftr_regs_t RST_VAL = '{
    state: dftr_pkg::ST_RECOVER, res_cnt: 32'h0, rec_cnt: 32'h0, stop_s: 2'h0, stop_prev: 1'b0,
    res_s: 2'h0, pwr_s: 2'h0, code: dftr_pkg::FC_NONE, retry_cnt: 8'h00, trip: 1'b1, fault: 1'b0,
    alarm: 1'b0, ready: 1'b0, disp: dftr_pkg::FC_NONE, flash: 1'b0, thermal_clr: 1'b1};

  // ==========================================================================
  // Decoding
  // ==========================================================================
  function automatic logic [7:0] phase_code(input logic [7:0] base, input logic [1:0] ph);
    logic [7:0] c;
    c = base;
    unique case (ph)
      dftr_pkg::PH_ACCEL: c = base;
      dftr_pkg::PH_CONST: c = base + 8'h01;
      dftr_pkg::PH_DECEL: c = base + 8'h02;
      dftr_pkg::PH_STOP: c = base + 8'h02;
    endcase
    return c;
  endfunction

  function automatic logic is_marked(input logic [7:0] c);
    return (c >= dftr_pkg::FC_MARK_LO) && (c <= dftr_pkg::FC_MARK_HI);
  endfunction

  logic stop_edge;
  logic res_act;
  logic res_valid;
  logic pwr_ok;
  logic fault_any;
  logic [7:0] fault_sel;

  always_comb begin
    stop_edge = st_reg.stop_s[1] & ~st_reg.stop_prev;
    res_act = st_reg.res_s[1];
    pwr_ok = st_reg.pwr_s[1];
    res_valid = res_act && (st_reg.res_cnt >= 32'(RES_MIN_CYC)); // [RULE11]
    fault_any = overcurrent_det_i | overvoltage_det_i | ext_fault_i | (st_reg.retry_cnt >= RETRY_LIMIT);
    if (overcurrent_det_i) begin
      fault_sel = phase_code(dftr_pkg::FC_OC_ACCEL, drive_phase_i); // [RULE13]
    end else if (overvoltage_det_i) begin
      fault_sel = phase_code(dftr_pkg::FC_OV_ACCEL, drive_phase_i); // [RULE14]
    end else if (st_reg.retry_cnt >= RETRY_LIMIT) begin
      fault_sel = dftr_pkg::FC_RETRY_EXCESS;
    end else begin
      fault_sel = ext_fault_code_i;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_next = st_reg;
    st_next.thermal_clr = 1'b0;
    st_next.stop_s = {st_reg.stop_s[0], stop_key_i};
    st_next.stop_prev = st_reg.stop_s[1];
    st_next.res_s = {st_reg.res_s[0], reset_request_input_i};
    st_next.pwr_s = {st_reg.pwr_s[0], power_ok_i};
    if (!res_act) begin
      st_next.res_cnt = 32'h0;
    end else if (st_reg.res_cnt < 32'(RES_MIN_CYC)) begin
      st_next.res_cnt = st_reg.res_cnt + 32'h1;
    end
    if (retry_attempt_i && (st_reg.retry_cnt != 8'hff)) begin
      st_next.retry_cnt = st_reg.retry_cnt + 8'h01;
    end
    if (!pwr_ok || res_valid) begin
      if (st_reg.state != dftr_pkg::ST_HOLD) begin
        st_next.thermal_clr = 1'b1; // [RULE7]
      end
      st_next.state = dftr_pkg::ST_HOLD; // [RULE10] [RULE12]
      st_next.retry_cnt = 8'h00; // [RULE7]
      st_next.code = dftr_pkg::FC_NONE;
    end else begin
      unique case (st_reg.state)
        dftr_pkg::ST_HOLD: begin
          st_next.retry_cnt = 8'h00;
          if (!res_act) begin
            st_next.state = dftr_pkg::ST_RECOVER;
            st_next.rec_cnt = 32'h0;
          end
        end
        dftr_pkg::ST_RECOVER: begin
          st_next.rec_cnt = st_reg.rec_cnt + 32'h1;
          if (fault_any) begin
            st_next.state = dftr_pkg::ST_TRIP;
            st_next.code = fault_sel;
          end else if (st_reg.rec_cnt >= 32'(RECOVER_CYC - 1)) begin
            st_next.state = dftr_pkg::ST_RUN; // [RULE8]
          end
        end
        dftr_pkg::ST_RUN: begin
          if (fault_any) begin
            st_next.state = dftr_pkg::ST_TRIP; // [RULE1] [RULE6]
            st_next.code = fault_sel; // [RULE18]
          end
        end
        dftr_pkg::ST_TRIP: begin
          if (stop_edge) begin
            st_next.state = dftr_pkg::ST_RECOVER; // [RULE9] [RULE2]
            st_next.rec_cnt = 32'h0;
            st_next.thermal_clr = 1'b1; // [RULE7]
            st_next.retry_cnt = 8'h00;
            st_next.code = dftr_pkg::FC_NONE;
          end
        end
      endcase
    end
    st_next.trip = (st_next.state != dftr_pkg::ST_RUN); // [RULE2]
    st_next.ready = (st_next.state == dftr_pkg::ST_RUN);
    st_next.fault = (st_next.state == dftr_pkg::ST_TRIP); // [RULE6]
    st_next.alarm = alarm_det_i & alarm_out_en_i; // [RULE5]
    st_next.flash = (st_next.state == dftr_pkg::ST_HOLD); // [RULE12]
    if (st_next.state == dftr_pkg::ST_HOLD) begin
      st_next.disp = dftr_pkg::DISP_RESET;
    end else if (st_next.state == dftr_pkg::ST_TRIP) begin
      st_next.disp = (legacy_unit_i && is_marked(st_next.code)) ? dftr_pkg::FC_GENERIC : st_next.code; // [RULE16]
    end else if (stall_overcurrent_warning_i) begin
      st_next.disp = dftr_pkg::DISP_STALL_OC; // [RULE15] [RULE4]
    end else if (stall_overvoltage_warning_i) begin
      st_next.disp = dftr_pkg::DISP_STALL_OV; // [RULE15]
    end else if (alarm_det_i) begin
      st_next.disp = dftr_pkg::DISP_ALARM;
    end else if (err_msg_i) begin
      st_next.disp = err_msg_code_i; // [RULE3] [RULE17]
    end else begin
      st_next.disp = dftr_pkg::FC_NONE;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign trip_o = st_reg.trip;
  assign fault_o = st_reg.fault;
  assign alarm_o = st_reg.alarm;
  assign ready_o = st_reg.ready;
  assign fault_code_o = st_reg.code;
  assign disp_code_o = st_reg.disp;
  assign disp_flash_o = st_reg.flash;
  assign thermal_clear_o = st_reg.thermal_clr;
  assign retry_count_o = st_reg.retry_cnt;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic quiet;
  assign quiet = pwr_ok && !res_valid;

  sequence s_run_fault;
    st_reg.state == dftr_pkg::ST_RUN && fault_any && quiet;
  endsequence

  sequence s_trip_idle;
    st_reg.state == dftr_pkg::ST_TRIP && quiet && !stop_edge;
  endsequence

  AST_FAULT_TRIP: assert property (s_run_fault |=> trip_o && fault_o && !ready_o) // [RULE1] [RULE6]
    else $error("fault did not trip output");
  AST_TRIP_HOLD: assert property (s_trip_idle |=> trip_o && fault_o && $stable(fault_code_o)) // [RULE2] [RULE18]
    else $error("trip or code released without reset");
  AST_NOFAULT_RUN: assert property (st_reg.state == dftr_pkg::ST_RUN && !fault_any && quiet
      && (err_msg_i || stall_overcurrent_warning_i || stall_overvoltage_warning_i || alarm_det_i)
      |=> ready_o && !trip_o) // [RULE3] [RULE4] [RULE5] [RULE17]
    else $error("non-fault condition stopped output");
  AST_ALARM_OUT: assert property (1'b1 |=> alarm_o == $past(alarm_det_i && alarm_out_en_i)) // [RULE5]
    else $error("alarm output wrong");
  AST_CLEAR: assert property (st_reg.state == dftr_pkg::ST_TRIP && stop_edge && quiet
      |=> thermal_clear_o && retry_count_o == 8'h00 ##1 !thermal_clear_o) // [RULE7] [RULE9]
    else $error("reset did not clear thermal and retry");
  AST_RECOVER_TIME: assert property ($rose(ready_o) |-> $past(st_reg.rec_cnt, 1) >= 32'(RECOVER_CYC - 1)) // [RULE8]
    else $error("ready before recovery delay");
  AST_STOP_NOTRIP: assert property (st_reg.state == dftr_pkg::ST_RUN && stop_edge && !fault_any && quiet
      |=> ready_o) // [RULE9]
    else $error("stop key reset outside trip");
  AST_POWER: assert property (!pwr_ok |=> st_reg.state == dftr_pkg::ST_HOLD && !fault_o) // [RULE10]
    else $error("power loss did not reset");
  AST_RES_SHORT: assert property (res_act && st_reg.res_cnt < 32'(RES_MIN_CYC) && pwr_ok
      && st_reg.state == dftr_pkg::ST_RUN && !fault_any |=> ready_o) // [RULE11]
    else $error("short reset request accepted");
  AST_HOLD_FLASH: assert property (res_valid && st_reg.res_s[0] // [RULE12]
      |=> (disp_flash_o && disp_code_o == dftr_pkg::DISP_RESET) [*2])
    else $error("reset indication missing");
  AST_OC_CODE: assert property (s_run_fault and overcurrent_det_i && drive_phase_i == dftr_pkg::PH_CONST
      |=> fault_code_o == dftr_pkg::FC_OC_CONST) // [RULE13]
    else $error("overcurrent code wrong");
  AST_OV_CODE: assert property (s_run_fault and !overcurrent_det_i && overvoltage_det_i
      && drive_phase_i == dftr_pkg::PH_STOP |=> fault_code_o == dftr_pkg::FC_OV_DECEL) // [RULE14]
    else $error("overvoltage code wrong");
  AST_STALL_DISP: assert property (st_reg.state == dftr_pkg::ST_RUN && !fault_any && quiet
      && !stall_overcurrent_warning_i && stall_overvoltage_warning_i |=> disp_code_o == dftr_pkg::DISP_STALL_OV) // [RULE15]
    else $error("stall warning display wrong");
  AST_LEGACY: assert property (s_trip_idle and legacy_unit_i && is_marked(fault_code_o) // [RULE16]
      |=> disp_code_o == dftr_pkg::FC_GENERIC)
    else $error("legacy generic code missing");

  sequence s_reset_entry;
    st_reg.state != dftr_pkg::ST_HOLD && (res_valid || !pwr_ok);
  endsequence

  AST_RESET_CLEAR: assert property (s_reset_entry // [RULE7] [RULE10]
      |=> thermal_clear_o && retry_count_o == 8'h00)
    else $error("reset entry did not clear thermal and retry");
  AST_DISP_TRIP: assert property (s_run_fault and !legacy_unit_i |=> disp_code_o == fault_code_o) // [RULE1]
    else $error("trip display does not show fault code");
  AST_ERR_DISP: assert property (st_reg.state == dftr_pkg::ST_RUN && !fault_any && quiet // [RULE3] [RULE17]
      && err_msg_i && !stall_overcurrent_warning_i && !stall_overvoltage_warning_i && !alarm_det_i
      |=> ready_o && disp_code_o == $past(err_msg_code_i))
    else $error("error message display wrong");

endmodule

// ===== dftr_panel_model.sv
// Purpose: Behavioural model of the operator panel, parameter unit and reset request line.
// Assumes: Lines change just after a rising clock edge.
// Notes: The bench calls the tasks of this module by hierarchical name.

`timescale 1ns/1ns

module dftr_panel_model (
  input wire logic clk_i,
  output logic stop_key_o,
  output logic reset_request_o,
  output logic legacy_unit_o
);
  // ==========================================================================
  // Panel lines
  // ==========================================================================
  initial begin
    stop_key_o = 1'b0;
    reset_request_o = 1'b0;
    legacy_unit_o = 1'b0;
  end

  // One full clock cycle of key press.
  task automatic press_stop();
    @(posedge clk_i);
    stop_key_o <= 1'b1;
    @(posedge clk_i);
    stop_key_o <= 1'b0;
  endtask

  // The caller holds the request for as long as the reset must last.
  task automatic set_reset(input logic v);
    @(posedge clk_i);
    reset_request_o <= v;
  endtask

  task automatic set_legacy(input logic v);
    @(posedge clk_i);
    legacy_unit_o <= v;
  endtask
endmodule

// ===== dftr_manager_tb.sv
// Purpose: Self-checking bench of the fault, trip and reset manager.
// Assumes: Shortened recovery and reset request counts.
// Notes: Outputs are sampled at the falling clock edge.

`timescale 1ns/1ns

module dftr_manager_tb;
  localparam int REC = 20;
  localparam int RMIN = 5;
  logic clk_i = 0, sys_rst_i = 1, power_ok_i = 1, oc = 0, ov = 0, ext = 0, retry = 0;
  logic swo = 0, swv = 0, al = 0, al_en = 0, em = 0;
  logic [1:0] drive_phase_i = 2'h1;
  logic [7:0] ext_code = 8'h00, em_code = 8'h41, e;
  logic stop_key, res_req, legacy;
  logic trip_o, fault_o, alarm_o, ready_o, disp_flash_o, thermal_clear_o;
  logic [7:0] fault_code_o, disp_code_o, retry_count_o;
  int failures = 0, num_checks = 0, n;

  // ==========================================================================
  // Instances
  // ==========================================================================
  dftr_panel_model PANEL (.clk_i(clk_i), .stop_key_o(stop_key), .reset_request_o(res_req),
    .legacy_unit_o(legacy));
  dftr_manager #(.RECOVER_CYC(REC), .RES_MIN_CYC(RMIN), .RETRY_LIMIT(8'h03)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .stop_key_i(stop_key), .reset_request_input_i(res_req),
    .power_ok_i(power_ok_i), .drive_phase_i(drive_phase_i), .overcurrent_det_i(oc),
    .overvoltage_det_i(ov), .ext_fault_i(ext), .ext_fault_code_i(ext_code), .retry_attempt_i(retry),
    .stall_overcurrent_warning_i(swo), .stall_overvoltage_warning_i(swv), .alarm_det_i(al),
    .alarm_out_en_i(al_en), .err_msg_i(em), .err_msg_code_i(em_code), .legacy_unit_i(legacy),
    .trip_o(trip_o), .fault_o(fault_o), .alarm_o(alarm_o), .ready_o(ready_o),
    .fault_code_o(fault_code_o), .disp_code_o(disp_code_o), .disp_flash_o(disp_flash_o),
    .thermal_clear_o(thermal_clear_o), .retry_count_o(retry_count_o));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk1(input string nm, input logic x, input logic g);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, x, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wait_ready(output int k);
    k = 0;
    @(negedge clk_i);
    while (ready_o !== 1'b1 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
  endtask

  task automatic recover_key();
    int k;
    PANEL.press_stop();
    k = 0;
    while (thermal_clear_o !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    chk1("thermal_clear", 1'b1, thermal_clear_o);
    chk8("retry_count", 8'h00, retry_count_o);
    chk1("fault", 1'b0, fault_o);
    chk1("trip_held", 1'b1, trip_o);
    wait_ready(k);
    chk1("recover_delay", 1'b1, k >= REC - 2 && k <= REC + 1);
  endtask

  task automatic fault_pulse(input logic [1:0] ph, input logic w);
    @(posedge clk_i);
    drive_phase_i <= ph;
    oc <= ~w;
    ov <= w;
    @(posedge clk_i);
    oc <= 1'b0;
    ov <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic show(input logic [3:0] m, input logic [7:0] x);
    @(posedge clk_i);
    em <= m[3];
    al <= m[2];
    swv <= m[1];
    swo <= m[0];
    cyc(4);
    chk8("disp_code", x, disp_code_o);
    chk1("no_trip", 1'b0, trip_o);
    chk1("alarm_out", m[2] & al_en, alarm_o);
    @(posedge clk_i);
    em <= 1'b0;
    al <= 1'b0;
    swv <= 1'b0;
    swo <= 1'b0;
    cyc(2);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_phase_faults();
    for (int w = 0; w < 2; w++) begin
      for (int p = 0; p < 4; p++) begin
        fault_pulse(p[1:0], w[0]);
        e = 8'(1 + w * 3 + (p > 2 ? 2 : p));
        chk8("fault_code", e, fault_code_o);
        chk8("disp_code", e, disp_code_o);
        chk1("trip", 1'b1, trip_o);
        chk1("fault", 1'b1, fault_o);
        fault_pulse(2'h0, ~w[0]);
        chk8("code_kept", e, fault_code_o);
        chk1("no_restart", 1'b0, ready_o);
        recover_key();
      end
    end
  endtask

  task automatic test_no_trip();
    show(4'h1, 8'h81);
    show(4'h2, 8'h82);
    show(4'h4, 8'h83);
    al_en <= 1'b1;
    show(4'h4, 8'h83);
    show(4'h8, 8'h41);
    em_code <= 8'h42;
    show(4'h8, 8'h42);
    PANEL.press_stop();
    cyc(8);
    chk1("key_in_run", 1'b1, ready_o);
  endtask

  task automatic test_reset_request();
    PANEL.set_reset(1'b1);
    cyc(RMIN - 3);
    PANEL.set_reset(1'b0);
    cyc(8);
    chk1("short_req", 1'b1, ready_o);
    retry <= 1'b1;
    cyc(1);
    retry <= 1'b0;
    PANEL.set_reset(1'b1);
    cyc(RMIN + 10);
    chk8("disp_reset", 8'h80, disp_code_o);
    chk1("flash", 1'b1, disp_flash_o);
    chk1("held_trip", 1'b1, trip_o);
    chk8("retry_cleared", 8'h00, retry_count_o);
    PANEL.set_reset(1'b0);
    wait_ready(n);
    chk1("res_recover", 1'b1, n >= REC - 2 && n <= REC + 4);
  endtask

  task automatic test_retry_legacy_power();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      retry <= 1'b1;
      @(posedge clk_i);
      retry <= 1'b0;
      cyc(2);
    end
    chk8("retry_fault", 8'h07, fault_code_o);
    recover_key();
    PANEL.set_legacy(1'b1);
    ext_code <= 8'h25;
    ext <= 1'b1;
    cyc(2);
    ext <= 1'b0;
    chk8("legacy_disp", 8'h0e, disp_code_o);
    chk8("legacy_code", 8'h25, fault_code_o);
    power_ok_i <= 1'b0;
    cyc(6);
    chk1("power_off", 1'b0, fault_o);
    power_ok_i <= 1'b1;
    wait_ready(n);
    chk1("power_on_trip", 1'b0, trip_o);
    chk8("power_on_code", 8'h00, fault_code_o);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_ready(n);
    chk1("startup_ready", 1'b1, ready_o);
    test_phase_faults();
    test_no_trip();
    test_reset_request();
    test_retry_legacy_power();
    summarize();
  end

  initial begin
    #5_000_000;
    failures++;
    summarize();
  end
endmodule
